// ### rtl/uiaw_map.svh
// register offsets, register widths, reset values and timing figures of the serial port interrupt logic
`ifndef UIAW_MAP_SVH
`define UIAW_MAP_SVH

`define UIAW_CTRL_OFF      12'h000
`define UIAW_INTC_OFF      12'h004
`define UIAW_STAT_OFF      12'h008

`define UIAW_CTRL_RST      9'h000
`define UIAW_INTC_RST      2'h0

`define UIAW_CTRL_W        9
`define UIAW_INTC_W        2
`define UIAW_STAT_W        11

`define UIAW_RESP_OKAY     2'b00
`define UIAW_RESP_SLVERR   2'b10

`define UIAW_CLK_MHZ       125
`define UIAW_RECOV_NS      1000

`endif

// ### rtl/uiaw_pkg.sv
// types shared by the serial port interrupt logic
package uiaw_pkg;

    // port_ctrl_two_reg fields, bit 8 downward
    typedef struct packed {
        logic receiver_on;
        logic port_on;
        logic parity_on;
        logic nine_bit_select;
        logic wake_en;
        logic addr_match_enable;
        logic rx_irq_mask_bit;
        logic tx_idle_ie;
        logic tx_empty_ie;
    } uiaw_ctrl_t;

    // processor-side interrupt control bits
    typedef struct packed {
        logic port_irq_gate;
        logic global_irq_gate;
    } uiaw_intc_t;

    // flags and events coming from the shifter and fifo logic
    typedef struct packed {
        logic       tx_empty_flag;
        logic       tx_idle_flag;
        logic       rx_avail_flag;
        logic       overrun_flag;
        logic       rx_trig_lvl;
        logic       rx_xfer;
        logic [8:0] rx_word;
    } uiaw_rx_evt_t;

    // the six interrupt sources after masking
    typedef struct packed {
        logic wake;
        logic addr;
        logic overrun;
        logic rx_trig;
        logic tx_idle;
        logic tx_empty;
    } uiaw_src_t;

    typedef enum logic [0:0] {
        UIAW_RUN,
        UIAW_RECOVER
    } uiaw_wake_st_t;

endpackage

// ### rtl/uiaw_sync.sv
// two flip-flop synchroniser for signals from outside the clock domain
`timescale 1ns/10ps
module uiaw_sync #(
    parameter int W = 1
) (
    input  wire logic         core_clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_r;

    // first stage feeds only the second stage
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            meta_r   <= '0;
            sync_out <= '0;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule

// ### rtl/uiaw_top.sv
// serial port interrupt, address-detect and wake-up logic with an axi4-lite register slave
//
// Functional notes
// - six sources raise the port interrupt: tx empty, tx idle, trigger, overrun, address, wake
// - an active interrupt shows as a one-cycle low pulse on the request line
// - vector only with global gate, port gate and return stack not full
// - each transmit source has its own enable bit in the control register
// - trigger and overrun share the receive enable and are masked together
// - address detect interrupts without a flag, only with address match enabled
// - status flags are read-only and not cleared by vectoring
// - port gate in the interrupt control register passes or masks the combined request
// - in address mode only words with top bit set interrupt, as addresses
// - qualifier is bit nine for nine-bit words, bit eight otherwise
// - without address mode every receive-available setting interrupts
// - port clock off halts activity; transmission pauses and resumes
// - reception under way at idle or sleep pauses, not aborts
// - idle or sleep leaves all port registers unchanged
// - falling receive edge while clock off wakes if all four enables set
// - receive data during wake recovery time is discarded
// - wake vectors only with global and port gates, else just wakes
// - wake interrupt withheld until the recovery time has elapsed
// - receive enable set: word moving into the buffer raises receive interrupt
// - receive enable set: overrun raises a receive interrupt
`timescale 1ns/10ps
`include "uiaw_map.svh"
module uiaw_top #(
    parameter int ADDR_W = 12
) (
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    // axi4-lite slave
    input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [ADDR_W-1:0]    s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    // shifter and fifo side, same clock
    input  wire uiaw_pkg::uiaw_rx_evt_t rx_evt,
    input  wire logic                 high_speed_clock_on,
    // processor side
    input  wire logic                 stack_full,
    // receive pin, asynchronous
    input  wire logic                 serial_rx_pin,
    output logic                      irq_req_n,
    output logic                      port_irq,
    output logic                      vector_take,
    output logic                      wake_req,
    output logic                      xfer_pause,
    output logic                      rx_discard
);
    import uiaw_pkg::*;

    localparam int RECOV_CYC_RAW = (`UIAW_RECOV_NS * `UIAW_CLK_MHZ) / 1000;
    localparam int RECOV_CYC     = (RECOV_CYC_RAW < 1) ? 1 : RECOV_CYC_RAW;
    localparam int CNT_W         = $clog2(RECOV_CYC + 1);

    uiaw_ctrl_t       ctrl_r;
    uiaw_intc_t       intc_r;
    uiaw_src_t        src;
    uiaw_wake_st_t    wake_st_r;
    logic [CNT_W-1:0] recov_cnt_r;
    logic             rx_pin_s;
    logic             rx_pin_d_r;
    logic             qual_r;
    logic             rx_word_pend_r;
    logic             addr_pend_r;
    logic             wake_pend_r;
    logic             port_req;
    logic             port_gated;
    logic             port_gated_d_r;
    logic             take;
    logic             qual_bit;
    logic             qual_ok;
    logic             fall_edge;
    logic             wake_hit;
    logic             recov_done;
    logic             rx_ok;
    logic [ADDR_W-1:0] awaddr_r;
    logic [31:0]      wdata_r;
    logic [3:0]       wstrb_r;
    logic             aw_have_r;
    logic             w_have_r;
    logic             wr_go;
    logic             rd_go;
    logic [`UIAW_STAT_W-1:0] stat;

    uiaw_sync #(
        .W (1)
    ) u_rx_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .async_in (serial_rx_pin),
        .sync_out (rx_pin_s)
    );

    // ---------------- axi4-lite write path ----------------
    assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            aw_have_r     <= 1'b0;
            awaddr_r      <= '0;
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= 1'b0;
            if (s_axi_awvalid && !aw_have_r && !s_axi_awready) begin
                awaddr_r      <= s_axi_awaddr;
                aw_have_r     <= 1'b1;
                s_axi_awready <= 1'b1;
            end else if (wr_go) begin
                aw_have_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            w_have_r     <= 1'b0;
            wdata_r      <= '0;
            wstrb_r      <= '0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= 1'b0;
            if (s_axi_wvalid && !w_have_r && !s_axi_wready) begin
                wdata_r      <= s_axi_wdata;
                wstrb_r      <= s_axi_wstrb;
                w_have_r     <= 1'b1;
                s_axi_wready <= 1'b1;
            end else if (wr_go) begin
                w_have_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `UIAW_RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            if (awaddr_r[11:0] == `UIAW_CTRL_OFF || awaddr_r[11:0] == `UIAW_INTC_OFF ||
                awaddr_r[11:0] == `UIAW_STAT_OFF) begin
                s_axi_bresp <= `UIAW_RESP_OKAY;
            end else begin
                s_axi_bresp <= `UIAW_RESP_SLVERR;
            end
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // idle keeps regs
    // control state only changes on bus writes, never on clock-off or sleep entry
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl_r <= uiaw_ctrl_t'(`UIAW_CTRL_RST);
        end else if (wr_go && awaddr_r[11:0] == `UIAW_CTRL_OFF) begin
            if (wstrb_r[0]) begin
                ctrl_r[7:0] <= wdata_r[7:0];
            end
            if (wstrb_r[1]) begin
                ctrl_r[8] <= wdata_r[8];
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            intc_r <= uiaw_intc_t'(`UIAW_INTC_RST);
        end else if (wr_go && awaddr_r[11:0] == `UIAW_INTC_OFF && wstrb_r[0]) begin
            intc_r <= wdata_r[`UIAW_INTC_W-1:0];
        end
    end

    // ---------------- axi4-lite read path ----------------
    assign rd_go = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;

    // flags read-only
    // flags mirror the shifter logic; writes to the status word are dropped
    assign stat = {ctrl_r.addr_match_enable & ctrl_r.parity_on, port_req, wake_pend_r, addr_pend_r,
                   (wake_st_r == UIAW_RECOVER), xfer_pause, rx_evt.rx_trig_lvl, rx_evt.overrun_flag,
                   rx_evt.rx_avail_flag, rx_evt.tx_idle_flag, rx_evt.tx_empty_flag};

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= `UIAW_RESP_OKAY;
        end else begin
            s_axi_arready <= 1'b0;
            if (rd_go) begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= `UIAW_RESP_OKAY;
                if (s_axi_araddr[11:0] == `UIAW_CTRL_OFF) begin
                    s_axi_rdata <= {{(32-`UIAW_CTRL_W){1'b0}}, ctrl_r};
                end else if (s_axi_araddr[11:0] == `UIAW_INTC_OFF) begin
                    s_axi_rdata <= {{(32-`UIAW_INTC_W){1'b0}}, intc_r};
                end else if (s_axi_araddr[11:0] == `UIAW_STAT_OFF) begin
                    s_axi_rdata <= {{(32-`UIAW_STAT_W){1'b0}}, stat};
                end else begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= `UIAW_RESP_SLVERR;
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ---------------- address qualification ----------------
    // qualifier bit
    assign qual_bit = ctrl_r.nine_bit_select ? rx_evt.rx_word[8] : rx_evt.rx_word[7];
    assign qual_ok  = !ctrl_r.addr_match_enable || qual_bit;
    assign rx_ok    = rx_evt.rx_xfer && (wake_st_r == UIAW_RUN);

    // in address mode the qualifier of the last word steers the trigger-level source
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            qual_r <= 1'b0;
        end else if (rx_ok) begin
            qual_r <= qual_ok;
        end
    end

    // word into buffer
    // set wins over the clear by vectoring
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rx_word_pend_r <= 1'b0;
        end else if (rx_ok && ctrl_r.rx_irq_mask_bit && qual_ok) begin
            rx_word_pend_r <= 1'b1;
        end else if (take) begin
            rx_word_pend_r <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            addr_pend_r <= 1'b0;
        end else if (rx_ok && ctrl_r.addr_match_enable && qual_bit) begin
            addr_pend_r <= 1'b1;
        end else if (take) begin
            addr_pend_r <= 1'b0;
        end
    end

    // ---------------- wake-up ----------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rx_pin_d_r <= 1'b0;
        end else begin
            rx_pin_d_r <= rx_pin_s;
        end
    end

    assign fall_edge = rx_pin_d_r && !rx_pin_s;
    assign wake_hit  = !high_speed_clock_on && fall_edge && ctrl_r.wake_en && ctrl_r.port_on &&
                       ctrl_r.receiver_on && ctrl_r.rx_irq_mask_bit;
    assign recov_done = (wake_st_r == UIAW_RECOVER) && (recov_cnt_r == CNT_W'(RECOV_CYC - 1));

    // the recovery timer runs on the always-on core clock, not on the port clock
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wake_st_r   <= UIAW_RUN;
            recov_cnt_r <= '0;
        end else begin
            case (wake_st_r)
                UIAW_RUN: begin
                    recov_cnt_r <= '0;
                    if (wake_hit) begin
                        wake_st_r <= UIAW_RECOVER;
                    end
                end
                UIAW_RECOVER: begin
                    recov_cnt_r <= recov_cnt_r + CNT_W'(1);
                    if (recov_done) begin
                        wake_st_r <= UIAW_RUN;
                    end
                end
                default: begin
                    wake_st_r <= UIAW_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wake_pend_r <= 1'b0;
        end else if (recov_done && intc_r.global_irq_gate && intc_r.port_irq_gate) begin
            wake_pend_r <= 1'b1;
        end else if (take) begin
            wake_pend_r <= 1'b0;
        end
    end

    // ---------------- source masking and combining ----------------
    // tx enables
    assign src.tx_empty = rx_evt.tx_empty_flag & ctrl_r.tx_empty_ie;
    assign src.tx_idle  = rx_evt.tx_idle_flag & ctrl_r.tx_idle_ie;
    assign src.rx_trig  = ctrl_r.rx_irq_mask_bit &
                          ((rx_evt.rx_trig_lvl & (qual_r | !ctrl_r.addr_match_enable)) | rx_word_pend_r);
    assign src.overrun  = ctrl_r.rx_irq_mask_bit & rx_evt.overrun_flag;
    assign src.addr     = addr_pend_r;
    assign src.wake     = wake_pend_r;

    assign port_req   = |src;
    assign port_gated = port_req & intc_r.port_irq_gate;
    // vector condition
    // one take per request edge; level flags stay set, which intact
    assign take       = port_gated && !port_gated_d_r && intc_r.global_irq_gate && !stack_full;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            port_gated_d_r <= 1'b0;
        end else begin
            port_gated_d_r <= port_gated;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq_req_n <= 1'b1;
        end else begin
            irq_req_n <= !(port_gated && !port_gated_d_r);
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            port_irq    <= 1'b0;
            vector_take <= 1'b0;
            wake_req    <= 1'b0;
        end else begin
            port_irq    <= port_gated;
            vector_take <= take;
            wake_req    <= wake_hit;
        end
    end

    // receive paused
    // pause, not reset: the shifters hold their state and carry on when this drops
    // discard window
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            xfer_pause <= 1'b0;
            rx_discard <= 1'b0;
        end else begin
            xfer_pause <= !high_speed_clock_on;
            rx_discard <= wake_hit || (wake_st_r == UIAW_RECOVER && !recov_done);
        end
    end

    // parity conflict
    // parity with address match is not blocked in hardware; stat bit 10 reports it
endmodule

// ### bench/uiaw_props.sv
// concurrent checks on the ports of the serial port interrupt logic
`timescale 1ns/10ps
module uiaw_props (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic high_speed_clock_on,
    input wire logic stack_full,
    input wire logic irq_req_n,
    input wire logic port_irq,
    input wire logic vector_take,
    input wire logic wake_req,
    input wire logic xfer_pause,
    input wire logic rx_discard
);
    logic [7:0] disc_cnt_r;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    // saturates so a stuck discard cannot wrap back into the window
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst)
            disc_cnt_r <= 8'h00;
        else if (!rx_discard)
            disc_cnt_r <= 8'h00;
        else if (disc_cnt_r != 8'hff)
            disc_cnt_r <= disc_cnt_r + 8'h01;
    end

    sequence s_low_once;
        !irq_req_n ##1 irq_req_n;
    endsequence
    sequence s_recover;
        rx_discard [*8];
    endsequence

    irq_pulse_a: assert property ($fell(irq_req_n) |-> s_low_once)
        else $error("request low for more than one cycle");
    pulse_on_rise_a: assert property (!irq_req_n |-> port_irq && !$past(port_irq))
        else $error("request pulse without a new port request");
    rise_gives_pulse_a: assert property ($rose(port_irq) |-> !irq_req_n)
        else $error("port request rose without a pulse");
    vector_cond_a: assert property (vector_take |-> !irq_req_n && !$past(stack_full))
        else $error("vector taken without pulse or with stack full");
    pause_track_a: assert property ($stable(high_speed_clock_on) |-> xfer_pause != high_speed_clock_on)
        else $error("pause does not follow the port clock");
    wake_clock_off_a: assert property (wake_req |-> !$past(high_speed_clock_on))
        else $error("wake request while the port clock runs");
    wake_discard_a: assert property (wake_req |-> s_recover)
        else $error("receive data not discarded after wake");
    recovery_len_a: assert property ($fell(rx_discard) |-> disc_cnt_r inside {[8'd120:8'd130]})
        else $error("wake recovery length wrong");
endmodule

bind uiaw_top uiaw_props u_props (
    .core_clk(core_clk), .rst(rst), .high_speed_clock_on(high_speed_clock_on), .stack_full(stack_full),
    .irq_req_n(irq_req_n), .port_irq(port_irq), .vector_take(vector_take), .wake_req(wake_req),
    .xfer_pause(xfer_pause), .rx_discard(rx_discard)
);

// ### bench/uiaw_far.sv
// far-side model: shifter and fifo events and the remote transmitter pin
`timescale 1ns/10ps
module uiaw_far (
    input  wire logic              core_clk,
    output uiaw_pkg::uiaw_rx_evt_t rx_evt,
    output logic                   serial_rx_pin
);
    import uiaw_pkg::*;

    initial begin
        rx_evt = '0;
        serial_rx_pin = 1'b1;
    end
    task automatic flags(input logic [4:0] f);
        @(posedge core_clk);
        rx_evt[14:10] <= f;
    endtask
    // word lines are scrambled once the pulse is over
    task automatic word(input logic [8:0] w);
        @(posedge core_clk);
        rx_evt.rx_xfer <= 1'b1;
        rx_evt.rx_word <= w;
        @(posedge core_clk);
        rx_evt.rx_xfer <= 1'b0;
        rx_evt.rx_word <= ~w;
    endtask
    // start bit, then the pulled-up idle level
    task automatic fall();
        @(posedge core_clk);
        serial_rx_pin <= 1'b0;
        repeat (10) @(posedge core_clk);
        serial_rx_pin <= 1'b1;
    endtask
endmodule

// ### bench/tb_uart_irq_addr_wake_logic.sv
// self-checking bench for the serial port interrupt logic
`timescale 1ns/10ps
`include "uiaw_map.svh"
module tb_uart_irq_addr_wake_logic;
    import uiaw_pkg::*;
    logic         core_clk, rst, awvalid, wvalid, bready, arvalid, rready, hsc, stack_full, pin;
    logic         awready, wready, bvalid, arready, rvalid, irq_req_n, port_irq, vector_take;
    logic         wake_req, xfer_pause, rx_discard;
    logic [11:0]  awaddr, araddr;
    logic [31:0]  wdata, rdata;
    logic [1:0]   bresp, rresp;
    logic [3:0]   wstrb;
    logic [8:0]   w;
    logic [65:0]  e;
    uiaw_rx_evt_t evt;
    int           n_fail, checked;
    int           eb[4] = '{14, 13, 11, 10};
    int           cb[4] = '{0, 1, 2, 2};
    logic [1:0]   exp_b[$];
    logic [65:0]  exp_r[$];
    logic         exp_i[$];

    uiaw_far far (.core_clk(core_clk), .rx_evt(evt), .serial_rx_pin(pin));
    uiaw_top uut (
        .core_clk(core_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rx_evt(evt),
        .high_speed_clock_on(hsc), .stack_full(stack_full), .serial_rx_pin(pin), .irq_req_n(irq_req_n),
        .port_irq(port_irq), .vector_take(vector_take), .wake_req(wake_req), .xfer_pause(xfer_pause),
        .rx_discard(rx_discard)
    );

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // the watcher pairs every answer with the oldest note
    always @(posedge core_clk) begin
        if (bvalid === 1'b1 && bready)
            chk(bresp, exp_b.pop_front());
        if (rvalid === 1'b1 && rready) begin
            e = exp_r.pop_front();
            chk(rdata & e[63:32], e[31:0]);
            chk(rresp, e[65:64]);
        end
        if (irq_req_n === 1'b0)
            chk(vector_take, exp_i.size() ? 32'(exp_i.pop_front()) : 32'h2);
    end
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        exp_b.push_back(r);
        @(posedge core_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] v, input logic [1:0] r);
        exp_r.push_back({r, m, v});
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (arready)
                arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
    endtask

    initial begin
        #(8 * 20000);
        n_fail++;
        final_report();
    end
    initial begin
        rst = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready, stack_full} = '0;
        hsc = 1'b1;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hf;
        n_fail = 0;
        checked = 0;
        void'($urandom(17));
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        rd(`UIAW_CTRL_OFF, 32'h1ff, `UIAW_CTRL_RST, `UIAW_RESP_OKAY);
        rd(`UIAW_INTC_OFF, 32'h3, `UIAW_INTC_RST, `UIAW_RESP_OKAY);
        // byte lanes: lane1 carries only bit 8, lane0 the low byte
        wstrb <= 4'h2;
        wr(`UIAW_CTRL_OFF, 32'h1ff, `UIAW_RESP_OKAY);
        rd(`UIAW_CTRL_OFF, 32'h1ff, 32'h100, `UIAW_RESP_OKAY);
        wstrb <= 4'h1;
        wr(`UIAW_CTRL_OFF, 32'h0fe, `UIAW_RESP_OKAY);
        rd(`UIAW_CTRL_OFF, 32'h1ff, 32'h1fe, `UIAW_RESP_OKAY);
        wstrb <= 4'hf;
        wr(`UIAW_CTRL_OFF, 32'h0, `UIAW_RESP_OKAY);
        far.flags(5'b10101);
        wr(`UIAW_STAT_OFF, 32'hffff_ffff, `UIAW_RESP_OKAY);
        rd(`UIAW_STAT_OFF, 32'h1f, 32'h15, `UIAW_RESP_OKAY);
        wr(12'h00c, 32'h1, `UIAW_RESP_SLVERR);
        rd(12'h00c, 32'hffff_ffff, 32'h0, `UIAW_RESP_SLVERR);
        far.flags(5'h0);
        wr(`UIAW_INTC_OFF, 32'h3, `UIAW_RESP_OKAY);
        for (int i = 0; i < 8; i++) begin
            wr(`UIAW_CTRL_OFF, i[0] ? 32'h1 << cb[i >> 1] : 32'h0, `UIAW_RESP_OKAY);
            if (i[0])
                exp_i.push_back(1'b1);
            far.flags(5'(1 << (eb[i >> 1] - 10)));
            repeat (6) @(posedge core_clk);
            rd(`UIAW_STAT_OFF, 32'h1f, 32'h1 << (14 - eb[i >> 1]), `UIAW_RESP_OKAY);
            far.flags(5'h0);
            repeat (4) @(posedge core_clk);
        end
        wr(`UIAW_CTRL_OFF, 32'h1, `UIAW_RESP_OKAY);
        for (int i = 0; i < 8; i++) begin
            wr(`UIAW_INTC_OFF, 32'(i & 3), `UIAW_RESP_OKAY);
            stack_full <= i[2];
            if (i[1])
                exp_i.push_back(i[0] & !i[2]);
            far.flags(5'h10);
            repeat (6) @(posedge core_clk);
            far.flags(5'h0);
            repeat (4) @(posedge core_clk);
        end
        stack_full <= 1'b0;
        wr(`UIAW_INTC_OFF, 32'h3, `UIAW_RESP_OKAY);
        for (int i = 0; i < 16; i++) begin
            wr(`UIAW_CTRL_OFF, 32'h184 | (32'(i[3]) << 3) | (32'(i[2]) << 5), `UIAW_RESP_OKAY);
            w = 9'($urandom);
            if (!i[3] || (i[2] ? w[8] : w[7]))
                exp_i.push_back(1'b1);
            far.word(w);
            repeat (6) @(posedge core_clk);
        end
        // port idle before the clock stops
        wr(`UIAW_CTRL_OFF, 32'h194, `UIAW_RESP_OKAY);
        hsc <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            wr(`UIAW_CTRL_OFF, i == 1 ? 32'h184 : 32'h194, `UIAW_RESP_OKAY);
            wr(`UIAW_INTC_OFF, i == 2 ? 32'h0 : 32'h3, `UIAW_RESP_OKAY);
            if (i == 0)
                exp_i.push_back(1'b1);
            far.fall();
            if (i != 1)
                far.word(9'h1ff);
            repeat (200) @(posedge core_clk);
        end
        rd(`UIAW_CTRL_OFF, 32'h1ff, 32'h194, `UIAW_RESP_OKAY);
        rd(`UIAW_STAT_OFF, 32'h20, 32'h20, `UIAW_RESP_OKAY);
        hsc <= 1'b1;
        repeat (10) @(posedge core_clk);
        chk(exp_i.size(), 32'h0);
        final_report();
    end
endmodule
